/* design/ircg_regs.vh */
// Register map, field positions and constants of the infrared code generator
`ifndef IRCG_REGS_VH
`define IRCG_REGS_VH
`define IRCG_A_CTRL 4'h0
`define IRCG_A_STAT 4'h1
`define IRCG_A_CAR_ON 4'h2
`define IRCG_A_CAR_OFF 4'h3
`define IRCG_A_ONE_MARK 4'h4
`define IRCG_A_ONE_SPACE 4'h5
`define IRCG_A_ZERO_MARK 4'h6
`define IRCG_A_ZERO_SPACE 4'h7
`define IRCG_A_RPT_TIME 4'h8
`define IRCG_A_CODE 4'h9
`define IRCG_A_RPT_WORD 4'ha
`define IRCG_C_START 0
`define IRCG_C_ONE_ORD 1
`define IRCG_C_ZERO_ORD 2
`define IRCG_C_INV 3
`define IRCG_C_KEY 4
`define IRCG_C_RPT_CLR 5
`define IRCG_S_BUSY 0
`define IRCG_S_DONE 1
`define IRCG_S_FULL 2
`define IRCG_S_EMPTY 3
`define IRCG_S_LVL_LSB 8
`define IRCG_W_TYPE 15
`define IRCG_W_SYM 14
`define IRCG_W_LEN_MSB 14
`define IRCG_W_LEN_LSB 11
`define IRCG_W_DUR_MSB 13
`define IRCG_MAX_LEN 4'ha
`define IRCG_RST16 16'h0000
`define IRCG_CLK_MHZ 100
`define IRCG_CAR_MAX_MHZ 16
`define IRCG_CODE_DEPTH 32
`define IRCG_CODE_AW 5
`define IRCG_RPT_DEPTH 8
`define IRCG_RPT_AW 3
`endif

/* design/ircg_top.v */
// Infrared code generator: code queue, decoder, modulator, carrier, repeat
// Operation
// R1 - Word bit 15 selects digital (1) or paint (0) handling.
// R2 - Digital: bits 14:11 are bit count minus one, payload in 10:0.
// R3 - Paint: bit 14 mark/space, bits 13:0 duration in carrier cycles.
// R4 - Words queue in code FIFO; decoder feeds modulator commands.
// R5 - Separate repeat FIFO holds words sent on key repeat.
// R6 - Held key starts repeat timer; retransmits automatically per interval.
// R7 - Software programs repeat interval before relying on repetition.
// R8 - Carrier runs on own gated clock up to 16 MHz.
// R9 - Carrier high for on-time, low for off-time carrier cycles.
// R10 - Modulator gate passes carrier in mark, blocks it in space.
// R11 - Modulator switches digital or paint handling per command.
// R12 - Logic one and zero are programmed mark and space counts.
// R13 - Per-logic-level flag picks mark-space or space-mark order.
// R14 - Output inverted when invert option set, else unchanged.
// R15 - Software enables block clock before programming timing.
// R16 - Software fills code FIFO, then sets transmit trigger.
// R17 - Code FIFO holds 32 words of 16 bits, written over bus.
// R18 - Interrupt request raised when transmission completes.
// R19 - Digital payload sent from highest valid bit down to bit 0.
// R20 - Transmission ends when FIFO empty and last symbol done; idle space.
`timescale 1ns/1ps
`include "ircg_regs.vh"
module ircg_top #(
  parameter [7:0] CAR_DIV = (`IRCG_CLK_MHZ + `IRCG_CAR_MAX_MHZ - 1) / `IRCG_CAR_MAX_MHZ,
  parameter CODE_DEPTH = `IRCG_CODE_DEPTH,
  parameter CODE_AW = `IRCG_CODE_AW,
  parameter RPT_DEPTH = `IRCG_RPT_DEPTH,
  parameter RPT_AW = `IRCG_RPT_AW
) (
  input wire CLK_SYS_I, // System clock
  input wire NRST_I, // Sync reset, active low
  input wire [3:0] ADDR_I, // Register index
  input wire [15:0] WDATA_I, // Write data
  input wire WR_I, // Write strobe
  input wire RD_I, // Read strobe
  input wire GENERATOR_CLOCK_GATE_BIT_I, // Carrier clock enable
  output reg [15:0] RDATA_O, // Read data, cycle after strobe
  output reg IR_O, // Emitter drive
  output reg IRQ_O // Completion pulse
);
  localparam ST_IDLE = 2'b00;
  localparam ST_FETCH = 2'b01;
  localparam ST_SYM = 2'b10;
  reg one_ord_r, zero_ord_r, inv_r, key_r;
  reg [15:0] car_on_r, car_off_r, one_mark_r, one_space_r;
  reg [15:0] zero_mark_r, zero_space_r, rpt_int_r;
  reg [15:0] cf_mem [0:CODE_DEPTH-1];
  reg [CODE_AW-1:0] cf_wp_r, cf_rp_r;
  reg [CODE_AW:0] cf_cnt_r;
  reg [15:0] rb_mem [0:RPT_DEPTH-1];
  reg [RPT_AW:0] rb_cnt_r;
  reg [RPT_AW:0] rb_idx_r;
  reg [7:0] div_cnt_r;
  reg tick_r, car_hi_r;
  reg [15:0] car_cnt_r;
  reg [1:0] st_r;
  reg src_rpt_r, start_pend_r, rpt_pend_r, rpt_run_r;
  reg [15:0] rpt_cnt_r, word_r;
  reg [3:0] bit_idx_r;
  reg ph_r, mark_r, done_r, fin_r;
  reg [15:0] sym_cnt_r;
  wire wr_ctrl = WR_I && (ADDR_I == `IRCG_A_CTRL);
  wire wr_stat = WR_I && (ADDR_I == `IRCG_A_STAT);
  wire cf_full = (cf_cnt_r == CODE_DEPTH[CODE_AW:0]);
  wire cf_empty = (cf_cnt_r == {(CODE_AW+1){1'b0}});
  wire cf_push = WR_I && (ADDR_I == `IRCG_A_CODE) && !cf_full; // [R17]
  wire rb_clr = wr_ctrl && WDATA_I[`IRCG_C_RPT_CLR];
  wire rb_push = WR_I && (ADDR_I == `IRCG_A_RPT_WORD) &&
                 (rb_cnt_r != RPT_DEPTH[RPT_AW:0]); // [R5]
  // Carrier generator: high on-time ticks, then low off-time ticks
  wire [15:0] car_len_w = car_hi_r ? car_on_r : car_off_r;
  wire car_end_w = ({1'b0, car_cnt_r} + 17'h00001) >= {1'b0, car_len_w};
  wire per_end_w = tick_r && !car_hi_r && car_end_w;
  // Decoder view of current command
  wire digital_w = word_r[`IRCG_W_TYPE]; // [R1]
  wire cur_bit_w = word_r[bit_idx_r]; // [R2]
  wire mfirst_w = cur_bit_w ? !one_ord_r : !zero_ord_r; // [R13]
  wire dig_mark_w = ph_r ? !mfirst_w : mfirst_w;
  wire [15:0] one_dur_w = dig_mark_w ? one_mark_r : one_space_r; // [R12]
  wire [15:0] zero_dur_w = dig_mark_w ? zero_mark_r : zero_space_r; // [R12]
  wire [15:0] dig_dur_w = cur_bit_w ? one_dur_w : zero_dur_w;
  wire [15:0] paint_dur_w = {2'b00, word_r[`IRCG_W_DUR_MSB:0]}; // [R3]
  wire sym_mark_w = digital_w ? dig_mark_w : word_r[`IRCG_W_SYM]; // [R11]
  wire [15:0] dur_w = digital_w ? dig_dur_w : paint_dur_w; // [R11]
  wire ph_end_w = tick_r && (({1'b0, sym_cnt_r} + 17'h00001) >= {1'b0, dur_w});
  wire src_avail_w = src_rpt_r ? (rb_idx_r < rb_cnt_r) : !cf_empty;
  wire [15:0] src_word_w = src_rpt_r ? rb_mem[rb_idx_r[RPT_AW-1:0]] : cf_mem[cf_rp_r];
  wire [3:0] len_w = src_word_w[`IRCG_W_LEN_MSB:`IRCG_W_LEN_LSB];
  wire cf_pop = (st_r == ST_FETCH) && !src_rpt_r && !cf_empty; // [R4]
  wire leave_idle_w = (st_r == ST_IDLE) && (start_pend_r || rpt_pend_r);

  always @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      one_ord_r <= 1'b0;
      zero_ord_r <= 1'b0;
      inv_r <= 1'b0;
      key_r <= 1'b0;
      car_on_r <= `IRCG_RST16;
      car_off_r <= `IRCG_RST16;
      one_mark_r <= `IRCG_RST16;
      one_space_r <= `IRCG_RST16;
      zero_mark_r <= `IRCG_RST16;
      zero_space_r <= `IRCG_RST16;
      rpt_int_r <= `IRCG_RST16;
    end else if (WR_I) begin
      if (ADDR_I == `IRCG_A_CTRL) begin
        one_ord_r <= WDATA_I[`IRCG_C_ONE_ORD];
        zero_ord_r <= WDATA_I[`IRCG_C_ZERO_ORD];
        inv_r <= WDATA_I[`IRCG_C_INV];
        key_r <= WDATA_I[`IRCG_C_KEY];
      end else if (ADDR_I == `IRCG_A_CAR_ON) begin
        car_on_r <= WDATA_I;
      end else if (ADDR_I == `IRCG_A_CAR_OFF) begin
        car_off_r <= WDATA_I;
      end else if (ADDR_I == `IRCG_A_ONE_MARK) begin
        one_mark_r <= WDATA_I;
      end else if (ADDR_I == `IRCG_A_ONE_SPACE) begin
        one_space_r <= WDATA_I;
      end else if (ADDR_I == `IRCG_A_ZERO_MARK) begin
        zero_mark_r <= WDATA_I;
      end else if (ADDR_I == `IRCG_A_ZERO_SPACE) begin
        zero_space_r <= WDATA_I;
      end else if (ADDR_I == `IRCG_A_RPT_TIME) begin
        rpt_int_r <= WDATA_I;
      end
    end
  end

  // Storage arrays carry no reset; pointers and counts define contents
  always @(posedge CLK_SYS_I) begin
    if (cf_push) begin
      cf_mem[cf_wp_r] <= WDATA_I; // [R17]
    end
    if (rb_push && !rb_clr) begin
      rb_mem[rb_cnt_r[RPT_AW-1:0]] <= WDATA_I; // [R5]
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      cf_wp_r <= {CODE_AW{1'b0}};
      cf_rp_r <= {CODE_AW{1'b0}};
      cf_cnt_r <= {(CODE_AW+1){1'b0}};
      rb_cnt_r <= {(RPT_AW+1){1'b0}};
    end else begin
      if (cf_push) begin
        cf_wp_r <= cf_wp_r + {{(CODE_AW-1){1'b0}}, 1'b1};
      end
      if (cf_pop) begin
        cf_rp_r <= cf_rp_r + {{(CODE_AW-1){1'b0}}, 1'b1};
      end
      if (cf_push && !cf_pop) begin
        cf_cnt_r <= cf_cnt_r + {{CODE_AW{1'b0}}, 1'b1};
      end else if (cf_pop && !cf_push) begin
        cf_cnt_r <= cf_cnt_r - {{CODE_AW{1'b0}}, 1'b1};
      end
      if (rb_clr) begin
        rb_cnt_r <= {(RPT_AW+1){1'b0}};
      end else if (rb_push) begin
        rb_cnt_r <= rb_cnt_r + {{RPT_AW{1'b0}}, 1'b1};
      end
    end
  end

  // Carrier clock is an enable pulse; gate bit stops it entirely
  always @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      div_cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else if (!GENERATOR_CLOCK_GATE_BIT_I) begin
      div_cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else if (div_cnt_r >= CAR_DIV - 8'h01) begin
      div_cnt_r <= 8'h00;
      tick_r <= 1'b1; // [R8]
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
      tick_r <= 1'b0;
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      car_hi_r <= 1'b1;
      car_cnt_r <= `IRCG_RST16;
    end else if (tick_r) begin
      if (car_end_w) begin
        car_hi_r <= !car_hi_r; // [R9]
        car_cnt_r <= `IRCG_RST16;
      end else begin
        car_cnt_r <= car_cnt_r + 16'h0001; // [R9]
      end
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      st_r <= ST_IDLE;
      src_rpt_r <= 1'b0;
      start_pend_r <= 1'b0;
      rpt_pend_r <= 1'b0;
      rpt_run_r <= 1'b0;
      rpt_cnt_r <= `IRCG_RST16;
      word_r <= `IRCG_RST16;
      bit_idx_r <= 4'h0;
      ph_r <= 1'b0;
      sym_cnt_r <= `IRCG_RST16;
      mark_r <= 1'b0;
      done_r <= 1'b0;
      fin_r <= 1'b0;
    end else begin
      fin_r <= 1'b0;
      if (wr_stat && WDATA_I[`IRCG_S_DONE]) begin
        done_r <= 1'b0;
      end
      case (st_r)
        ST_IDLE: begin
          mark_r <= 1'b0;
          if (start_pend_r) begin
            start_pend_r <= 1'b0;
            src_rpt_r <= 1'b0;
            st_r <= ST_FETCH;
          end else if (rpt_pend_r) begin
            rpt_pend_r <= 1'b0;
            src_rpt_r <= 1'b1;
            rb_idx_r <= {(RPT_AW+1){1'b0}};
            st_r <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          mark_r <= 1'b0;
          if (!src_avail_w) begin
            st_r <= ST_IDLE; // [R20]
            done_r <= 1'b1; // [R18]
            fin_r <= 1'b1; // [R18]
          end else begin
            word_r <= src_word_w; // [R4]
            if (src_rpt_r) begin
              rb_idx_r <= rb_idx_r + {{RPT_AW{1'b0}}, 1'b1};
            end
            // Lengths above ten are clamped so the index stays in the payload
            bit_idx_r <= (len_w > `IRCG_MAX_LEN) ? `IRCG_MAX_LEN : len_w; // [R19]
            ph_r <= 1'b0;
            sym_cnt_r <= `IRCG_RST16;
            st_r <= ST_SYM;
          end
        end
        ST_SYM: begin
          mark_r <= sym_mark_w; // [R10]
          if (tick_r) begin
            sym_cnt_r <= ph_end_w ? `IRCG_RST16 : sym_cnt_r + 16'h0001;
          end
          if (ph_end_w) begin
            if (!digital_w) begin
              st_r <= ST_FETCH; // [R3]
            end else if (!ph_r) begin
              ph_r <= 1'b1; // [R13]
            end else if (bit_idx_r == 4'h0) begin
              st_r <= ST_FETCH; // [R19]
            end else begin
              ph_r <= 1'b0;
              bit_idx_r <= bit_idx_r - 4'h1; // [R19]
            end
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
      // Repeat timer counts whole carrier periods for a long reach
      if (leave_idle_w && key_r) begin
        rpt_run_r <= 1'b1; // [R6]
        rpt_cnt_r <= rpt_int_r; // [R6]
      end else if (!key_r) begin
        rpt_run_r <= 1'b0;
      end else if (rpt_run_r && per_end_w) begin
        if (rpt_cnt_r <= 16'h0001) begin
          rpt_run_r <= 1'b0;
          if (rb_cnt_r != {(RPT_AW+1){1'b0}}) begin
            rpt_pend_r <= 1'b1; // [R6]
          end
        end else begin
          rpt_cnt_r <= rpt_cnt_r - 16'h0001;
        end
      end
      if (!key_r) begin
        rpt_pend_r <= 1'b0;
      end
      // Trigger written during take-over still counts: set after clear
      if (wr_ctrl && WDATA_I[`IRCG_C_START]) begin
        start_pend_r <= 1'b1; // [R16]
      end
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      IR_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      IR_O <= inv_r ^ (mark_r && car_hi_r); // [R14]
      IRQ_O <= fin_r; // [R18]
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      RDATA_O <= `IRCG_RST16;
    end else if (!RD_I) begin
      RDATA_O <= `IRCG_RST16;
    end else if (ADDR_I == `IRCG_A_CTRL) begin
      RDATA_O <= {10'h000, 1'b0, key_r, inv_r, zero_ord_r, one_ord_r, start_pend_r};
    end else if (ADDR_I == `IRCG_A_STAT) begin
      RDATA_O <= {{(8-CODE_AW-1){1'b0}}, cf_cnt_r, 4'h0, cf_empty, cf_full, done_r,
                  (st_r != ST_IDLE) || start_pend_r};
    end else if (ADDR_I == `IRCG_A_CAR_ON) begin
      RDATA_O <= car_on_r;
    end else if (ADDR_I == `IRCG_A_CAR_OFF) begin
      RDATA_O <= car_off_r;
    end else if (ADDR_I == `IRCG_A_ONE_MARK) begin
      RDATA_O <= one_mark_r;
    end else if (ADDR_I == `IRCG_A_ONE_SPACE) begin
      RDATA_O <= one_space_r;
    end else if (ADDR_I == `IRCG_A_ZERO_MARK) begin
      RDATA_O <= zero_mark_r;
    end else if (ADDR_I == `IRCG_A_ZERO_SPACE) begin
      RDATA_O <= zero_space_r;
    end else if (ADDR_I == `IRCG_A_RPT_TIME) begin
      RDATA_O <= rpt_int_r;
    end else begin
      RDATA_O <= `IRCG_RST16;
    end
  end
endmodule

/* test/ircg_emitter.sv */
// Emitter-side model: measures high runs on the drive pin
`timescale 1ns/1ps
module ircg_emitter (
  input wire clk_i, // System clock
  input wire ir_i // Drive pin seen by the emitter
);
  int runs[$]; // Completed high runs, in clock cycles
  int cnt = 0;
  always @(posedge clk_i) begin
    if (ir_i === 1'b1) begin
      cnt <= cnt + 1;
    end else if (cnt != 0) begin
      runs.push_back(cnt);
      cnt <= 0;
    end
  end
endmodule

/* test/ircg_top_asserts.sv */
// Port-level checker for the infrared code generator
`timescale 1ns/1ps
`include "ircg_regs.vh"
module ircg_chk (
  input wire CLK_SYS_I, // System clock
  input wire NRST_I, // Sync reset, active low
  input wire [3:0] ADDR_I, // Register index
  input wire [15:0] WDATA_I, // Write data
  input wire WR_I, // Write strobe
  input wire RD_I, // Read strobe
  input wire [15:0] RDATA_O, // Read data
  input wire IR_O, // Emitter drive
  input wire IRQ_O // Completion pulse
);
  reg inv_r; // Invert option as last written
  reg started_r; // Some start was requested
  always @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      inv_r <= 1'b0;
      started_r <= 1'b0;
    end else if (WR_I && ADDR_I == `IRCG_A_CTRL) begin
      inv_r <= WDATA_I[`IRCG_C_INV];
      started_r <= started_r | WDATA_I[`IRCG_C_START];
    end
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);
  sequence s_stat_rd;
    RD_I && ADDR_I == `IRCG_A_STAT;
  endsequence
  sequence s_pulse;
    IRQ_O ##1 !IRQ_O;
  endsequence
  chk_irq_one_cycle: assert property (IRQ_O |-> s_pulse)
    else $error("completion pulse longer than one cycle");
  chk_irq_after_start: assert property (IRQ_O |-> started_r)
    else $error("completion without any start");
  chk_idle_level: assert property (IRQ_O |-> IR_O == inv_r)
    else $error("pin not at idle level at completion");
  chk_rdata_quiet: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
    else $error("read data outside its cycle");
  chk_unmapped_zero: assert property (RD_I && ADDR_I > `IRCG_A_RPT_WORD |=> RDATA_O == 16'h0000)
    else $error("unmapped read not zero");
  chk_full_level: assert property (s_stat_rd |=> RDATA_O[2] == (RDATA_O[13:8] == 6'd32))
    else $error("full flag disagrees with level");
  chk_empty_level: assert property (s_stat_rd |=> RDATA_O[3] == (RDATA_O[13:8] == 6'd0))
    else $error("empty flag disagrees with level");
  chk_level_max: assert property (s_stat_rd |=> RDATA_O[13:8] <= 6'd32)
    else $error("code queue level above depth");
  chk_reset_outs: assert property ($rose(NRST_I) |-> !IR_O && !IRQ_O && RDATA_O == 16'h0000)
    else $error("outputs not idle after reset");
endmodule
bind ircg_top ircg_chk u_chk (.CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .IR_O(IR_O), .IRQ_O(IRQ_O));

/* test/tb.sv */
// Self-checking bench for the infrared code generator
`timescale 1ns/1ps
`include "ircg_regs.vh"
module tb;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [15:0] wdata = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg gate = 1'b1; // Block clock enabled before any programming
  wire [15:0] rdata;
  wire ir;
  wire irq;
  int fails = 0;
  int total_checks = 0;
  int irqs = 0;
  int i;
  int base;
  logic [15:0] v;
  always #5 clk = ~clk;
  // Fast carrier divider keeps symbol runs equal to tick counts
  ircg_top #(.CAR_DIV(8'd1)) DUT (.CLK_SYS_I(clk), .NRST_I(nrst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .GENERATOR_CLOCK_GATE_BIT_I(gate),
    .RDATA_O(rdata), .IR_O(ir), .IRQ_O(irq));
  ircg_emitter em (.clk_i(clk), .ir_i(ir));
  always @(posedge clk) begin
    if (irq === 1'b1) irqs <= irqs + 1;
  end
  function logic [15:0] pw(input logic sym, input logic [13:0] dur);
    return {1'b0, sym, dur};
  endfunction
  task check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task rd_reg(input logic [3:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  // Start and wait, bounded, for the completion pulse
  task go(input logic [15:0] ctrl);
    int t;
    int k;
    t = irqs + 1;
    wr_reg(`IRCG_A_CTRL, ctrl | 16'h0001);
    for (k = 0; k < 4000 && irqs < t; k++) @(posedge clk);
    check(16'(irqs), 16'(t));
    repeat (3) @(posedge clk);
  endtask
  task chk_runs(input int n, input int a, input int b, input int c);
    int e[3];
    int k;
    e = '{a, b, c};
    check(16'(em.runs.size()), 16'(n));
    for (k = 0; k < n && em.runs.size() > 0; k++) check(16'(em.runs.pop_front()), 16'(e[k]));
    em.runs.delete();
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_reg(`IRCG_A_STAT, v);
    check(v, 16'h0008);
    rd_reg(4'hf, v);
    check(v, 16'h0000);
    // Carrier held high: pin shows the bare envelope
    wr_reg(`IRCG_A_CAR_ON, 16'hffff);
    wr_reg(`IRCG_A_ONE_MARK, 16'h0003);
    wr_reg(`IRCG_A_ONE_SPACE, 16'h0002);
    wr_reg(`IRCG_A_ZERO_MARK, 16'h0001);
    wr_reg(`IRCG_A_ZERO_SPACE, 16'h0004);
    rd_reg(`IRCG_A_ZERO_SPACE, v);
    check(v, 16'h0004);
    for (i = 0; i < 33; i++) wr_reg(`IRCG_A_CODE, pw(1'b0, 14'h0000));
    rd_reg(`IRCG_A_STAT, v);
    check(v, 16'h2004);
    go(16'h0000);
    rd_reg(`IRCG_A_STAT, v);
    check(v, 16'h000a);
    wr_reg(`IRCG_A_STAT, 16'h0002);
    rd_reg(`IRCG_A_STAT, v);
    check(v, 16'h0008);
    chk_runs(0, 0, 0, 0);
    // Three bits 101, junk in payload bit 10 above the valid bits ignored
    wr_reg(`IRCG_A_CODE, 16'h9405);
    go(16'h0000);
    chk_runs(3, 3, 1, 3);
    wr_reg(`IRCG_A_CODE, 16'h9405);
    go(16'h0002);
    chk_runs(2, 4, 3, 0);
    wr_reg(`IRCG_A_CODE, 16'h9405);
    go(16'h0004);
    chk_runs(2, 3, 4, 0);
    rd_reg(`IRCG_A_CTRL, v);
    check(v, 16'h0004);
    wr_reg(`IRCG_A_CODE, pw(1'b1, 14'd5));
    wr_reg(`IRCG_A_CODE, pw(1'b0, 14'd2));
    wr_reg(`IRCG_A_CODE, pw(1'b1, 14'd0));
    wr_reg(`IRCG_A_CODE, pw(1'b0, 14'd1));
    wr_reg(`IRCG_A_CODE, 16'h8001);
    go(16'h0000);
    chk_runs(3, 5, 1, 3);
    // Gate dropped mid-mark stretches the mark
    wr_reg(`IRCG_A_CODE, pw(1'b1, 14'd6));
    wr_reg(`IRCG_A_CTRL, 16'h0001);
    for (i = 0; i < 50 && ir !== 1'b1; i++) @(posedge clk);
    @(posedge clk);
    gate <= 1'b0;
    // Status read takes two of the ten gated cycles
    rd_reg(`IRCG_A_STAT, v);
    check(v, 16'h000b);
    repeat (8) @(posedge clk);
    gate <= 1'b1;
    repeat (40) @(posedge clk);
    chk_runs(1, 16, 0, 0);
    wr_reg(`IRCG_A_CTRL, 16'h0008);
    repeat (3) @(posedge clk);
    check(16'(ir), 16'h0001);
    wr_reg(`IRCG_A_CODE, pw(1'b1, 14'd4));
    go(16'h0008);
    check(16'(ir), 16'h0001);
    wr_reg(`IRCG_A_CTRL, 16'h0000);
    repeat (3) @(posedge clk);
    em.runs.delete();
    // Repeat interval programmed before the held key
    wr_reg(`IRCG_A_CAR_ON, 16'h0001);
    wr_reg(`IRCG_A_CAR_OFF, 16'h0001);
    wr_reg(`IRCG_A_RPT_TIME, 16'h0003);
    wr_reg(`IRCG_A_RPT_WORD, pw(1'b0, 14'd2));
    wr_reg(`IRCG_A_CODE, pw(1'b0, 14'd2));
    base = irqs;
    wr_reg(`IRCG_A_CTRL, 16'h0011);
    for (i = 0; i < 600 && irqs < base + 2; i++) @(posedge clk);
    check(16'(irqs >= base + 2), 16'h0001);
    wr_reg(`IRCG_A_CTRL, 16'h0000);
    repeat (100) @(posedge clk);
    base = irqs;
    repeat (200) @(posedge clk);
    check(16'(irqs - base), 16'h0000);
    // Cleared repeat queue: held key gives no retransmission
    wr_reg(`IRCG_A_CTRL, 16'h0020);
    base = irqs;
    wr_reg(`IRCG_A_CTRL, 16'h0011);
    repeat (100) @(posedge clk);
    check(16'(irqs - base), 16'h0001);
    wr_reg(`IRCG_A_CTRL, 16'h0000);
    conclude();
  end
endmodule
